// file: ooers_pkg.sv
`default_nettype none
package ooers_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // scaling constants, output voltages held as signed millivolts
  localparam logic [31:0] FS_MV            = 32'h0000_2710; // 10 V
  localparam logic [31:0] AUX_UNITY_MV     = 32'h0000_03E8; // 1.000 V
  localparam logic [31:0] OFFSET_MAX       = 32'h0001_863C; // 999 percent
  localparam logic [31:0] NORM_LIM         = 32'h3FFF_FFFF;
  localparam logic [31:0] PHASE_MDEG_PER_MV = 32'h0000_0012; // 18 deg/V
  localparam logic [7:0]  MULT_X1          = 8'h01;
  localparam logic [7:0]  MULT_X10         = 8'h0A;
  localparam logic [7:0]  MULT_X100        = 8'h64;
  localparam logic [5:0]  DIV_LAST         = 6'h2F; // 48 quotient bits

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SENS   = 8'h04;
  localparam logic [7:0] ADDR_CFG_X  = 8'h08;
  localparam logic [7:0] ADDR_CFG_Y  = 8'h0C;
  localparam logic [7:0] ADDR_CFG_R  = 8'h10;
  localparam logic [7:0] ADDR_CMD    = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_PRI    = 8'h1C;
  localparam logic [7:0] ADDR_SEC    = 8'h20;

  // field positions
  localparam int CTRL_PRI_MAG_BIT = 0;
  localparam int CTRL_SEC_PH_BIT  = 1;
  localparam int CFG_OFS_LSB      = 0;
  localparam int OFS_W            = 18;
  localparam int CFG_EXP_LSB      = 20;
  localparam int CFG_RATIO_BIT    = 24;
  localparam int CFG_OFS_ON_BIT   = 28;
  localparam int CMD_ACT_LSB      = 0;
  localparam int CMD_CH_BIT       = 4;
  localparam int CMD_STEP_LSB     = 8;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SENS_RST = 32'h000F_4240;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    EXP_X1   = 2'h0,
    EXP_X10  = 2'h1,
    EXP_X100 = 2'h2
  } ooers_exp_type;

  typedef enum logic [2:0] {
    ACT_NONE   = 3'h0,
    ACT_TOGGLE = 3'h1,
    ACT_AUTO   = 3'h2,
    ACT_ADJUST = 3'h3,
    ACT_EXPAND = 3'h4,
    ACT_RATIO  = 3'h5
  } ooers_act_type;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_LOAD_N = 4'h1,
    ST_RUN_N  = 4'h2,
    ST_FIN_N  = 4'h3,
    ST_LOAD_R = 4'h4,
    ST_RUN_R  = 4'h5,
    ST_FIN_R  = 4'h6,
    ST_EVAL   = 4'h7,
    ST_LOAD_P = 4'h8,
    ST_RUN_P  = 4'h9,
    ST_FIN_P  = 4'hA,
    ST_PUB    = 4'hB
  } ooers_state_type;

  typedef struct packed {
    logic signed [31:0] x;
    logic signed [31:0] y;
    logic signed [31:0] r;
    logic signed [31:0] phase; // millidegrees
  } ooers_sample_type;

  typedef struct packed {
    logic signed [31:0] chart;   // offset and ratio, no expand
    logic signed [15:0] numeric; // offset and ratio, no expand
    logic signed [15:0] bar;     // follows the channel output
    logic               scale;
    logic               offset_ind;
    logic               ratio_ind;
    logic               exp10_ind;
    logic               exp100_ind;
  } ooers_disp_type;

endpackage : ooers_pkg
`default_nettype wire

// file: ooers_scaler.sv
`timescale 1ns/1ps
`default_nettype none
module ooers_scaler
  import ooers_pkg::*;
(
  input  wire logic             CLK_SYS_IN,      // 40 MHz clock
  input  wire logic             RST_B_IN,        // async reset, active low
  input  wire logic             PSEL_IN,         // apb select
  input  wire logic             PENABLE_IN,      // apb access phase
  input  wire logic             PWRITE_IN,       // apb write
  input  wire logic [7:0]       PADDR_IN,        // apb byte address
  input  wire logic [31:0]      PWDATA_IN,       // apb write data
  output logic      [31:0]      PRDATA_OUT,      // apb read data
  output logic                  PREADY_OUT,      // apb ready
  output logic                  PSLVERR_OUT,     // apb error, unmapped
  input  wire logic             SAMPLE_VALID_IN, // new demod result
  input  wire ooers_sample_type SAMPLE_IN,       // x, y, r, phase
  input  wire logic signed [15:0] AUX_MV_IN,     // ratio input in mV
  output logic                  BUSY_OUT,        // samples dropped
  output logic signed [15:0]    PRIMARY_OUTPUT_CHANNEL_OUT,   // mV
  output logic signed [15:0]    SECONDARY_OUTPUT_CHANNEL_OUT, // mV
  output logic signed [15:0]    REAR_X_OUT,      // mV
  output logic signed [15:0]    REAR_Y_OUT,      // mV
  output logic                  OVERLOAD_LED_OUT, // output overload
  output ooers_disp_type        PRIMARY_DISP_OUT,   // channel one view
  output ooers_disp_type        SECONDARY_DISP_OUT  // channel two view
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // magnitude of a signed word
  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    abs32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : abs32

  // clip a magnitude to a limit and give it back its sign
  function automatic logic signed [31:0] clip_mag(
    input logic [47:0] mag, input logic neg, input logic [31:0] lim);
    logic [31:0] m;
    m = (mag > {16'h0000, lim}) ? lim : mag[31:0];
    clip_mag = neg ? -$signed(m) : $signed(m);
  endfunction : clip_mag

  // keep a stored offset inside its percentage range
  function automatic logic signed [17:0] clip_ofs(
    input logic signed [31:0] v);
    logic signed [31:0] c;
    c = clip_mag({16'h0000, abs32(v)}, v[31], OFFSET_MAX);
    clip_ofs = c[17:0];
  endfunction : clip_ofs

  function automatic logic [7:0] exp_mult(input logic [1:0] code);
    case (code)
      EXP_X10:  exp_mult = MULT_X10;
      EXP_X100: exp_mult = MULT_X100;
      default:  exp_mult = MULT_X1;
    endcase
  endfunction : exp_mult

  ////////////////////////////////////////////////////////////////////////////
  // state

  ooers_state_type    state;
  logic [1:0]         qi;          // 0 x, 1 y, 2 magnitude
  ooers_sample_type   smp;
  logic signed [15:0] aux;
  logic [31:0]        ctrl;
  logic [31:0]        sens;
  logic signed [17:0] ofs [3];
  logic               ofs_on [3];
  logic [1:0]         expd [3];
  logic               rat_on [3];
  logic signed [31:0] nrm [3];
  logic signed [31:0] cur_q;
  logic               dz;
  logic signed [31:0] r_chart [3];
  logic signed [15:0] r_num [3];
  logic signed [15:0] r_bar [3];
  logic               r_ovl [3];
  logic signed [15:0] ph_out;
  logic [47:0]        dv_quo;
  logic [32:0]        dv_rem;
  logic [31:0]        dv_den;
  logic               dv_neg;
  logic [5:0]         dv_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // shared restoring divider, one quotient bit per clock
  wire [32:0] dv_try = {dv_rem[31:0], dv_quo[47]};
  wire        dv_ge  = dv_try >= {1'b0, dv_den};
  wire [32:0] dv_sub = dv_try - {1'b0, dv_den};
  // a zero divisor gives an all-ones quotient, so it clips to the limit
  wire signed [31:0] dv_res  = clip_mag(dv_quo, dv_neg, NORM_LIM);
  wire signed [31:0] ph_res  = clip_mag(dv_quo, dv_neg, FS_MV);

  ////////////////////////////////////////////////////////////////////////////
  // per-quantity datapath terms
  wire signed [31:0] meas_q = (qi == 2'h0) ? smp.x :
                              (qi == 2'h1) ? smp.y : smp.r;
  wire [47:0] norm_dvd = {16'h0000, abs32(meas_q)} * {16'h0000, FS_MV};
  wire signed [31:0] ofs_app = ofs_on[qi] ? 32'(ofs[qi]) : 32'sh0;
  wire signed [31:0] dif     = dv_res - ofs_app;
  wire [47:0] rat_dvd = {16'h0000, abs32(cur_q)} * {16'h0000, AUX_UNITY_MV};
  wire [31:0] aux_mag = abs32(32'(aux));
  wire [47:0] ph_dvd  = {16'h0000, abs32(smp.phase)};
  wire signed [47:0] exp_val = $signed({{16{cur_q[31]}}, cur_q}) *
                               $signed({40'h0, exp_mult(expd[qi])});
  wire [47:0] exp_mag  = exp_val[47] ? 48'(-exp_val) : 48'(exp_val);
  wire        eval_ovl = dz | (exp_mag > {16'h0000, FS_MV});
  wire signed [31:0] bar_w = clip_mag(exp_mag, exp_val[47], FS_MV);
  // overload pins numeric at full scale with its own sign
  wire signed [31:0] num_w = clip_mag(eval_ovl ? 48'hFFFF_FFFF_FFFF :
                               {16'h0000, abs32(cur_q)}, cur_q[31],
                               FS_MV);

  ////////////////////////////////////////////////////////////////////////////
  // sample sequencer: x, y and magnitude in turn, then phase
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state  <= ST_IDLE;
      qi     <= 2'h0;
      smp    <= '0;
      aux    <= 16'sh0;
      cur_q  <= 32'sh0;
      dz     <= 1'b0;
      ph_out <= 16'sh0;
      dv_quo <= 48'h0;
      dv_rem <= 33'h0;
      dv_den <= 32'h0;
      dv_neg <= 1'b0;
      dv_cnt <= 6'h0;
      for (int i = 0; i < 3; i++) begin
        nrm[i]     <= 32'sh0;
        r_chart[i] <= 32'sh0;
        r_num[i]   <= 16'sh0;
        r_bar[i]   <= 16'sh0;
        r_ovl[i]   <= 1'b0;
      end
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (SAMPLE_VALID_IN) begin
            smp   <= SAMPLE_IN;
            aux   <= AUX_MV_IN;
            qi    <= 2'h0;
            state <= ST_LOAD_N;
          end
        end
        ST_LOAD_N: begin
          // full scale when the quantity equals the sensitivity
          dv_quo <= norm_dvd;
          dv_rem <= 33'h0;
          dv_den <= sens;
          dv_neg <= meas_q[31];
          dz     <= (sens == 32'h0);
          dv_cnt <= DIV_LAST;
          state  <= ST_RUN_N;
        end
        ST_LOAD_R: begin
          dv_quo <= rat_dvd;
          dv_rem <= 33'h0;
          dv_den <= aux_mag;
          dv_neg <= cur_q[31] ^ aux[15];
          dz     <= dz | (aux == 16'sh0);
          dv_cnt <= DIV_LAST;
          state  <= ST_RUN_R;
        end
        ST_LOAD_P: begin
          dv_quo <= ph_dvd;
          dv_rem <= 33'h0;
          dv_den <= PHASE_MDEG_PER_MV;
          dv_neg <= smp.phase[31];
          dv_cnt <= DIV_LAST;
          state  <= ST_RUN_P;
        end
        ST_RUN_N, ST_RUN_R, ST_RUN_P: begin
          dv_rem <= dv_ge ? dv_sub : dv_try;
          dv_quo <= {dv_quo[46:0], dv_ge};
          dv_cnt <= dv_cnt - 6'h1;
          if (dv_cnt == 6'h0) begin
            state <= (state == ST_RUN_N) ? ST_FIN_N :
                     (state == ST_RUN_R) ? ST_FIN_R : ST_FIN_P;
          end
        end
        ST_FIN_N: begin
          nrm[qi] <= dv_res;
          cur_q   <= dif;
          state   <= rat_on[qi] ? ST_LOAD_R : ST_EVAL;
        end
        ST_FIN_R: begin
          cur_q <= dv_res;
          state <= ST_EVAL;
        end
        ST_EVAL: begin
          // chart keeps offset and ratio but not expand or clipping
          r_chart[qi] <= cur_q;
          r_num[qi]   <= num_w[15:0];
          r_bar[qi]   <= bar_w[15:0];
          r_ovl[qi]   <= eval_ovl;
          qi          <= qi + 2'h1;
          state       <= (qi == 2'h2) ? ST_LOAD_P : ST_LOAD_N;
        end
        ST_FIN_P: begin
          ph_out <= ph_res[15:0];
          state  <= ST_PUB;
        end
        ST_PUB: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display assembly for one quantity
  function automatic ooers_disp_type mk_disp(input logic [1:0] q);
    ooers_disp_type d;
    d.chart      = r_chart[q];
    d.numeric    = r_num[q];
    d.bar        = r_bar[q];
    d.scale      = r_ovl[q];
    d.offset_ind = ofs_on[q];
    d.ratio_ind  = rat_on[q];
    d.exp10_ind  = (expd[q] == EXP_X10);
    d.exp100_ind = (expd[q] == EXP_X100);
    mk_disp = d;
  endfunction : mk_disp

  wire            pri_mag  = ctrl[CTRL_PRI_MAG_BIT];
  wire            sec_ph   = ctrl[CTRL_SEC_PH_BIT];
  wire [1:0]      pri_q    = pri_mag ? 2'h2 : 2'h0;
  wire            any_ovl  = r_ovl[0] | r_ovl[1] | (pri_mag & r_ovl[2]);
  wire ooers_disp_type ph_disp = '{chart: smp.phase, numeric: ph_out,
                                   bar: ph_out, default: 1'b0};

  // channel, rear, lamp and display outputs change together once per processed sample; busy updates every clock
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PRIMARY_OUTPUT_CHANNEL_OUT   <= 16'sh0;
      SECONDARY_OUTPUT_CHANNEL_OUT <= 16'sh0;
      REAR_X_OUT                   <= 16'sh0;
      REAR_Y_OUT                   <= 16'sh0;
      OVERLOAD_LED_OUT             <= 1'b0;
      PRIMARY_DISP_OUT             <= '0;
      SECONDARY_DISP_OUT           <= '0;
      BUSY_OUT                     <= 1'b0;
    end else begin
      BUSY_OUT <= (state != ST_IDLE) | SAMPLE_VALID_IN;
      if (state == ST_PUB) begin
        REAR_X_OUT                   <= r_bar[0];
        REAR_Y_OUT                   <= r_bar[1];
        PRIMARY_OUTPUT_CHANNEL_OUT   <= r_bar[pri_q];
        SECONDARY_OUTPUT_CHANNEL_OUT <= sec_ph ? ph_out : r_bar[1];
        OVERLOAD_LED_OUT             <= any_ovl;
        PRIMARY_DISP_OUT             <= mk_disp(pri_q);
        SECONDARY_DISP_OUT           <= sec_ph ? ph_disp : mk_disp(2'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, data staged in the setup cycle
  wire        apb_setup = PSEL_IN & ~PENABLE_IN;
  wire        apb_wr    = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire        hit_cfg   = (PADDR_IN == ADDR_CFG_X) |
                          (PADDR_IN == ADDR_CFG_Y) |
                          (PADDR_IN == ADDR_CFG_R);
  wire [1:0]  cfg_q     = (PADDR_IN == ADDR_CFG_X) ? 2'h0 :
                          (PADDR_IN == ADDR_CFG_Y) ? 2'h1 : 2'h2;
  wire        mapped    = hit_cfg | (PADDR_IN == ADDR_CTRL) |
                          (PADDR_IN == ADDR_SENS) | (PADDR_IN == ADDR_CMD) |
                          (PADDR_IN == ADDR_STATUS) |
                          (PADDR_IN == ADDR_PRI) | (PADDR_IN == ADDR_SEC);
  wire [2:0]  cmd_act   = PWDATA_IN[CMD_ACT_LSB +: 3];
  wire        cmd_ch    = PWDATA_IN[CMD_CH_BIT];
  wire signed [17:0] cmd_step = PWDATA_IN[CMD_STEP_LSB +: OFS_W];
  // the source selection decides which quantity the controls touch
  wire [1:0]  tgt_q     = cmd_ch ? 2'h1 : pri_q;
  wire        tgt_ok    = ~(cmd_ch & sec_ph);
  wire        do_cmd    = apb_wr & (PADDR_IN == ADDR_CMD) & tgt_ok;

  function automatic logic [31:0] cfg_word(input logic [1:0] q);
    logic [31:0] w;
    w = 32'h0;
    w[CFG_OFS_LSB +: OFS_W]   = ofs[q];
    w[CFG_EXP_LSB +: 2]       = expd[q];
    w[CFG_RATIO_BIT]          = rat_on[q];
    w[CFG_OFS_ON_BIT]         = ofs_on[q];
    cfg_word = w;
  endfunction : cfg_word

  wire [31:0] status_w = {25'h0, r_ovl[2], r_ovl[1], r_ovl[0],
                          2'h0, OVERLOAD_LED_OUT, BUSY_OUT};
  wire [31:0] rd_mux =
    (PADDR_IN == ADDR_CTRL)   ? ctrl :
    (PADDR_IN == ADDR_SENS)   ? sens :
    hit_cfg                   ? cfg_word(cfg_q) :
    (PADDR_IN == ADDR_STATUS) ? status_w :
    (PADDR_IN == ADDR_PRI)    ? 32'(PRIMARY_OUTPUT_CHANNEL_OUT) :
    (PADDR_IN == ADDR_SEC)    ? 32'(SECONDARY_OUTPUT_CHANNEL_OUT) : 32'h0;

  // bus answer registers
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PRDATA_OUT  <= 32'h0;
      PREADY_OUT  <= 1'b1;
      PSLVERR_OUT <= 1'b0;
    end else if (apb_setup) begin
      PRDATA_OUT  <= PWRITE_IN ? 32'h0 : rd_mux;
      PREADY_OUT  <= 1'b1;
      PSLVERR_OUT <= ~mapped;
    end
  end

  // settings: direct writes plus the front-panel style commands.
  // only one settings write can land per clock, so no merge is needed
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl <= CTRL_RST;
      sens <= SENS_RST;
      for (int i = 0; i < 3; i++) begin
        ofs[i]    <= 18'sh0;
        ofs_on[i] <= 1'b0;
        expd[i]   <= EXP_X1;
        rat_on[i] <= 1'b0;
      end
    end else if (apb_wr) begin
      if (PADDR_IN == ADDR_CTRL) begin
        ctrl <= {30'h0, PWDATA_IN[CTRL_SEC_PH_BIT:CTRL_PRI_MAG_BIT]};
      end
      if (PADDR_IN == ADDR_SENS) begin
        sens <= PWDATA_IN;               // offsets stay put
      end
      if (hit_cfg) begin
        ofs[cfg_q]    <= clip_ofs(
                           32'($signed(PWDATA_IN[CFG_OFS_LSB +: OFS_W])));
        expd[cfg_q]   <= (PWDATA_IN[CFG_EXP_LSB +: 2] == 2'h3) ? EXP_X1 :
                         PWDATA_IN[CFG_EXP_LSB +: 2];
        rat_on[cfg_q] <= PWDATA_IN[CFG_RATIO_BIT];
        ofs_on[cfg_q] <= PWDATA_IN[CFG_OFS_ON_BIT];
      end
      if (do_cmd) begin
        unique case (cmd_act)
          ACT_TOGGLE: ofs_on[tgt_q] <= ~ofs_on[tgt_q];
          ACT_AUTO: begin
            ofs[tgt_q]    <= clip_ofs(nrm[tgt_q]);
            ofs_on[tgt_q] <= 1'b1;
          end
          ACT_ADJUST: ofs[tgt_q] <= clip_ofs(32'(ofs[tgt_q]) +
                                             32'(cmd_step));
          ACT_EXPAND: expd[tgt_q] <= (expd[tgt_q] == EXP_X100) ? EXP_X1 :
                                     expd[tgt_q] + 2'h1;
          ACT_RATIO:  rat_on[tgt_q] <= ~rat_on[tgt_q];
          default: begin
          end
        endcase
      end
    end
  end

endmodule : ooers_scaler
`default_nettype wire

// file: ooers_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ooers_checker
  import ooers_pkg::*;
(
  input wire logic               CLK_SYS_IN,  // clock
  input wire logic               RST_B_IN,    // reset, active low
  input wire logic [31:0]        PRDATA_OUT,  // read data
  input wire logic               PREADY_OUT,  // apb ready
  input wire logic               PSLVERR_OUT, // apb error
  input wire logic               BUSY_OUT,    // sequencer busy
  input wire logic signed [15:0] PRIMARY_OUTPUT_CHANNEL_OUT, // ch one
  input wire logic signed [15:0] REAR_X_OUT,  // rear x
  input wire logic signed [15:0] REAR_Y_OUT,  // rear y
  input wire logic               OVERLOAD_LED_OUT,  // lamp
  input wire ooers_disp_type     PRIMARY_DISP_OUT,  // view one
  input wire ooers_disp_type     SECONDARY_DISP_OUT // view two
);
  localparam logic signed [15:0] fs = 16'(FS_MV);
  // a rear output at either rail is an overload the lamp may stand for
  wire logic rail_x = (REAR_X_OUT == fs) || (REAR_X_OUT == -fs);
  wire logic rail_y = (REAR_Y_OUT == fs) || (REAR_Y_OUT == -fs);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  ////////////////////////////////////////
  chk_ready_high: assert property (PREADY_OUT)
    else $error("ready dropped");
  chk_err_zero: assert property (PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
    else $error("error read returned data");
  chk_rear_clip: assert property (
    REAR_X_OUT <= fs && REAR_X_OUT >= -fs && REAR_Y_OUT <= fs &&
    REAR_Y_OUT >= -fs) else $error("rear output beyond full scale");
  chk_pin_sign: assert property (
    PRIMARY_DISP_OUT.scale |-> PRIMARY_DISP_OUT.numeric == fs ||
    PRIMARY_DISP_OUT.numeric == -fs) else $error("numeric not pinned");
  chk_exp_single: assert property (
    !(PRIMARY_DISP_OUT.exp10_ind && PRIMARY_DISP_OUT.exp100_ind))
    else $error("two expand lamps lit");
  // at unity expand an unclipped numeric must equal its bar exactly
  chk_unity_same: assert property (
    !PRIMARY_DISP_OUT.exp10_ind && !PRIMARY_DISP_OUT.exp100_ind &&
    !PRIMARY_DISP_OUT.scale |-> PRIMARY_DISP_OUT.numeric ==
    PRIMARY_DISP_OUT.bar) else $error("numeric differs at unity");
  chk_bar_follow: assert property (
    PRIMARY_DISP_OUT.bar == PRIMARY_OUTPUT_CHANNEL_OUT)
    else $error("bar differs from output");
  // busy drops one edge after the publish edge that moves the lamp
  chk_led_edge: assert property (
    $rose(OVERLOAD_LED_OUT) |=> $fell(BUSY_OUT))
    else $error("lamp rose outside publish");
  chk_led_shown: assert property (OVERLOAD_LED_OUT |->
    PRIMARY_DISP_OUT.scale || SECONDARY_DISP_OUT.scale || rail_x || rail_y)
    else $error("lamp without marked display");
  chk_out_hold: assert property (!BUSY_OUT && !$past(BUSY_OUT) |->
    $stable(REAR_X_OUT) && $stable(PRIMARY_OUTPUT_CHANNEL_OUT))
    else $error("outputs moved while idle");
  chk_busy_span: assert property ($rose(BUSY_OUT) |-> ##[100:500]
    $fell(BUSY_OUT)) else $error("sequence too long");
endmodule : ooers_checker
bind ooers_scaler ooers_checker ooers_checker_i (
  .CLK_SYS_IN, .RST_B_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .BUSY_OUT,
  .PRIMARY_OUTPUT_CHANNEL_OUT, .REAR_X_OUT, .REAR_Y_OUT, .OVERLOAD_LED_OUT,
  .PRIMARY_DISP_OUT, .SECONDARY_DISP_OUT);
`default_nettype wire

// file: ooers_sink.sv
`timescale 1ns/1ps
`default_nettype none
module ooers_sink (
  input  wire logic        clk_in,   // sample clock
  input  wire logic        rst_b_in, // reset, active low
  input  wire logic        busy_in,  // scaler sequencing
  input  wire logic [63:0] level_in, // four converter codes
  input  wire logic        led_in,   // overload lamp
  output logic      [64:0] held_out, // lamp and codes as latched
  output logic             taken_out // high for one cycle from the latch edge
);
  logic busy_d;
  // latch only once busy drops, so a half-updated set never converts
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_d <= 1'b0;
      taken_out <= 1'b0;
      held_out <= '0;
    end else begin
      busy_d <= busy_in;
      taken_out <= busy_d && !busy_in;
      if (busy_d && !busy_in) held_out <= {led_in, level_in};
    end
  end
endmodule : ooers_sink
`default_nettype wire

// file: ooers_scaler_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
  fails++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module ooers_scaler_test
  import ooers_pkg::*;
;
  typedef struct packed {
    logic [64:0] v;   // lamp, primary, secondary, rear x, rear y
    logic [15:0] num; // primary numeric
    logic [3:0]  fl;  // offset, ratio, x10, x100 lamps
  } ooers_note_type;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic sv = 1'b0, busy, pready, pslverr, led, taken;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rnd;
  logic signed [15:0] aux = 16'sh0, pri, sec, rx, ry;
  ooers_sample_type smp = '0;
  ooers_disp_type pd;
  logic [64:0] held;
  logic [32:0] rq[$], r;
  ooers_note_type nq[$], n;
  int fails = 0, comparisons = 0, x;
  wire logic [3:0] fl_seen = {pd.offset_ind, pd.ratio_ind, pd.exp10_ind,
                              pd.exp100_ind};
  ooers_scaler ooers_scaler_i (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .SAMPLE_VALID_IN(sv), .SAMPLE_IN(smp), .AUX_MV_IN(aux), .BUSY_OUT(busy),
    .PRIMARY_OUTPUT_CHANNEL_OUT(pri), .SECONDARY_OUTPUT_CHANNEL_OUT(sec),
    .REAR_X_OUT(rx), .REAR_Y_OUT(ry), .OVERLOAD_LED_OUT(led),
    .PRIMARY_DISP_OUT(pd), .SECONDARY_DISP_OUT());
  ooers_sink ooers_sink_i (.clk_in(clk), .rst_b_in(rst_b), .busy_in(busy),
    .level_in({pri, sec, rx, ry}), .led_in(led), .held_out(held),
    .taken_out(taken));
  ////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  function automatic ooers_note_type nt(input int p, s, a, b,
    input logic l, input int m, input logic [3:0] f);
    return {l, 16'(p), 16'(s), 16'(a), 16'(b), 16'(m), f};
  endfunction : nt
  // the next sample waits for idle, since pulses while busy are dropped
  task automatic run(input int xv, yv, rv, ph, input logic [15:0] ax,
                     input ooers_note_type e);
    int k;
    nq.push_back(e);
    smp <= '{x: xv, y: yv, r: rv, phase: ph};
    aux <= ax;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    repeat (3) @(posedge clk);
    for (k = 0; k < 600 && busy !== 1'b0; k++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : run
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial begin
    forever #12.5 clk = ~clk;
  end
  // results are judged once latched downstream, reads during access
  always @(negedge clk) begin
    if (taken === 1'b1 && nq.size() > 0) begin
      n = nq.pop_front();
      `CHK("outputs", n.v, held)
      `CHK("numeric", n.num, pd.numeric)
      `CHK("flags", n.fl, fl_seen)
    end
    if (psel && pen && !pwr && rq.size() > 0) begin
      r = rq.pop_front();
      `CHK("read", r, {pslverr, prdata})
    end
  end
  // generous bound: ten samples of under 400 cycles each
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    rnd = $urandom(74);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(ADDR_SENS, {1'b0, SENS_RST});
    rd(8'h24, 33'h1_0000_0000);
    // expand code 3 is refused and must read back later as unity
    apb(1'b1, ADDR_CFG_R, 32'h0030_0000);
    run(32'shF4240, -32'sh7A120, 32'sh0, 32'sh0, 16'h0, nt(16'sh2710,
      -16'sh1388, 16'sh2710, -16'sh1388, 1'b0, 16'sh2710, 4'h0));
    apb(1'b1, ADDR_CTRL, 32'h3);
    // a negative offset of 30 percent must add to the output
    apb(1'b1, ADDR_CFG_X, 32'h1003_F448);
    run(32'sh61A80, 32'sh0, 32'sh3D090, 32'sh15F90, 16'h0, nt(16'sh09C4,
      16'sh1388, 16'sh1B58, 16'sh0, 1'b0, 16'sh09C4, 4'h0));
    rd(ADDR_SEC, 33'h0_0000_1388);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_CFG_X, 32'h1010_07D0);
    apb(1'b1, ADDR_CFG_Y, 32'h0020_0000);
    run(32'sh493E0, -32'sh30D40, 32'sh0, 32'sh0, 16'h0, nt(16'sh2710,
      -16'sh2710, 16'sh2710, -16'sh2710, 1'b1, 16'sh03E8, 4'hA));
    rd(ADDR_STATUS, 33'h0_0000_0022);
    apb(1'b1, ADDR_CFG_X, 32'h0100_0000);
    apb(1'b1, ADDR_CFG_Y, 32'h0);
    run(32'sh61A80, 32'sh186A0, 32'sh0, 32'sh0, 16'h07D0, nt(16'sh07D0,
      16'sh03E8, 16'sh07D0, 16'sh03E8, 1'b0, 16'sh07D0, 4'h4));
    run(32'sh61A80, 32'sh186A0, 32'sh0, 32'sh0, 16'h0, nt(16'sh2710,
      16'sh03E8, 16'sh2710, 16'sh03E8, 1'b1, 16'sh2710, 4'h4));
    apb(1'b1, ADDR_CFG_X, 32'h0);
    for (int i = 0; i < 3; i++) begin
      x = int'($urandom_range(32'h1E8480)) - 32'shF4240;
      rnd = $urandom;
      run(x, 32'sh0, 32'sh0, 32'sh0, rnd[15:0], nt(x / 32'sh64, 32'sh0,
        x / 32'sh64, 32'sh0, 1'b0, x / 32'sh64, 4'h0));
    end
    apb(1'b1, ADDR_CFG_X, 32'h0000_03E8);
    apb(1'b1, ADDR_CMD, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h0001_F403);
    apb(1'b1, ADDR_CMD, 32'h1);
    rd(ADDR_CFG_X, 33'h0_1000_05DC);
    run(32'sh7A120, 32'sh0, 32'sh0, 32'sh0, 16'h0, nt(16'sh0DAC, 16'sh0,
      16'sh0DAC, 16'sh0, 1'b0, 16'sh0DAC, 4'h8));
    apb(1'b1, ADDR_CMD, 32'h2);
    run(32'sh7A120, 32'sh0, 32'sh0, 32'sh0, 16'h0, nt(16'sh0, 16'sh0,
      16'sh0, 16'sh0, 1'b0, 16'sh0, 4'h8));
    apb(1'b1, ADDR_CMD, 32'h4);
    apb(1'b1, ADDR_CMD, 32'h5);
    rd(ADDR_CFG_X, 33'h0_1110_1388);
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_CMD, 32'h0000_6403);
    apb(1'b1, ADDR_CMD, 32'h0000_6413);
    rd(ADDR_CFG_R, 33'h0_0000_0064);
    rd(ADDR_CFG_Y, 33'h0);
    `CHK("pending", 0, nq.size() + rq.size())
    complete_run();
  end
endmodule : ooers_scaler_test
`default_nettype wire
